/* File: hw/spo_top.sv */
// stepper pulse output stage with ahb-lite register access
`timescale 1ns/10ps
// What this block does
// - stop input low ends the running motion
// - setting picks immediate halt or decelerated stop
// - start with stop low completes without pulses
// - stop event still flagged after such start
// - filter rejects three or under, accepts four cycles
// - unfiltered input takes pulses of any width
// - one filter enable covers all four inputs
// - mode 0 puts plus and minus pulses apart
// - mode 1 gives pulse plus direction level
// - logic setting picks idle high or low
// - phase outputs carry sequence when port and mask 0
// - drive type pin latched during reset
// - step size pin used live, unlatched
// - odd step then full mode goes two-phase
// - unipolar full step four fixed patterns
// - bipolar full step, phases 3 4 low
// - origin flag set only at step zero
// - mask forces phases low or 3 4 high
// - step advances as pulse turns off
// - status bits 8 to 11 show phases
// - reset phases HLLH, bipolar goes HLLL at first clock after reset
module spo_top
   import spo_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic external_stop_input_n,
   input wire logic origin_input_n,
   input wire logic plus_end_limit_input_n,
   input wire logic minus_end_limit_input_n,
   input wire logic unipolar_bipolar_select,
   input wire logic half_step_select,
   input wire logic [3:0] gpio_in,
   output logic first_pulse_output,
   output logic second_pulse_output,
   output logic [3:0] phase_output,
   output logic [3:0] phase_oe,
   output logic origin_filtered_n,
   output logic plus_end_limit_filtered_n,
   output logic minus_end_limit_filtered_n
);
   spo_seq_if sif();
   spo_state_e state;
   spo_state_e next_state;
   logic [31:0] ctrl;
   logic [3:0] gpio_out;
   logic [3:0] gpio_dir;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic bipolar_latch;
   logic reset_seen;
   logic dir_plus;
   logic pulse_on;
   logic [15:0] tick;
   logic [7:0] decel_cnt;
   logic stop_event;
   logic stop_n;
   logic org_n;
   logic pel_n;
   logic mel_n;
   logic [3:0] gpio_in_q;
   logic addr_ok;
   logic cmd_wr;
   logic start_req;
   logic halt_req;
   logic tick_end;
   logic pulse_end;
   logic stop_low;
   logic [3:0] seq_phase;
   logic [3:0] mask_phase;
   logic [3:0] next_phase;
   logic pulse_lvl;
   logic [31:0] status;
   logic [31:0] rd_mux;

   // ==========================================================
   // input filters, one enable shared by all four
   spo_filter u_stop (.clock(clock), .rstn(rstn), .enable(ctrl[SPO_CTL_FILT]),
      .raw_n(external_stop_input_n), .clean_n(stop_n));
   spo_filter u_org (.clock(clock), .rstn(rstn), .enable(ctrl[SPO_CTL_FILT]),
      .raw_n(origin_input_n), .clean_n(org_n));
   spo_filter u_pel (.clock(clock), .rstn(rstn), .enable(ctrl[SPO_CTL_FILT]),
      .raw_n(plus_end_limit_input_n), .clean_n(pel_n));
   spo_filter u_mel (.clock(clock), .rstn(rstn), .enable(ctrl[SPO_CTL_FILT]),
      .raw_n(minus_end_limit_input_n), .clean_n(mel_n));

   // ==========================================================
   // excitation sequencer
   spo_seq u_seq (.clock(clock), .rstn(rstn), .sif(sif.seq));

   assign sif.advance = pulse_end;
   assign sif.dir_plus = dir_plus;
   assign sif.half_step = half_step_select;
   assign sif.bipolar = bipolar_latch;
   assign seq_phase = sif.phase;

   // drive type pin caught while reset holds, frozen afterwards
   always_ff @(posedge clock) begin
      if (!rstn) begin
         bipolar_latch <= unipolar_bipolar_select;
      end
   end

   // marks that reset has run once, for clean outputs after it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reset_seen <= 1'b0;
      end else begin
         reset_seen <= 1'b1;
      end
   end

   // ==========================================================
   // ahb-lite slave, zero wait states, always okay
   assign addr_ok = hsel && hready && htrans[1];
   assign cmd_wr = wr_pend && (wr_addr == SPO_CMD_OFS);
   assign start_req = cmd_wr && hwdata[SPO_CMD_START];
   assign halt_req = cmd_wr && hwdata[SPO_CMD_HALT];

   // address phase capture for writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // control register and general-purpose port
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl <= SPO_CTRL_RST;
      end else if (wr_pend && (wr_addr == SPO_CTRL_OFS)) begin
         ctrl <= {hwdata[31:16], 9'h000, hwdata[6:0]};
      end
   end

   // port bits share the control word high half
   assign gpio_out = ctrl[19:16];
   assign gpio_dir = ctrl[23:20];

   // registered general-purpose inputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gpio_in_q <= 4'h0;
      end else begin
         gpio_in_q <= gpio_in;
      end
   end

   // status word, phase levels in bits 8 to 11
   assign status = {16'h0000, 4'h0, phase_output, 3'h0, sif.origin, 1'b0,
      ~stop_n, stop_event, (state != SPO_IDLE)};

   // read data selection
   assign rd_mux = (haddr[7:0] == SPO_CTRL_OFS) ? ctrl :
      (haddr[7:0] == SPO_STAT_OFS) ? status :
      (haddr[7:0] == SPO_CMD_OFS) ? {28'h0000000, gpio_in_q} : 32'h0000_0000;

   // read data register, unmapped addresses read zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // ==========================================================
   // motion control
   assign tick_end = (tick == SPO_HALF_PERIOD - 16'h0001);
   assign pulse_end = tick_end && pulse_on && (state != SPO_IDLE);
   assign stop_low = !stop_n;

   // next motion state
   always_comb begin
      next_state = state;
      case (state)
         SPO_IDLE: begin
            if (start_req && !stop_low) begin
               next_state = SPO_RUN;
            end
         end
         SPO_RUN: begin
            if (halt_req || (stop_low && !ctrl[SPO_CTL_STOPDEC])) begin
               next_state = SPO_IDLE;
            end else if (stop_low) begin
               next_state = SPO_DECEL;
            end
         end
         SPO_DECEL: begin
            if (halt_req || (pulse_end && decel_cnt == 8'h01)) begin
               next_state = SPO_IDLE;
            end
         end
         default: next_state = SPO_IDLE;
      endcase
   end

   // motion registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= SPO_IDLE;
         dir_plus <= 1'b1;
         tick <= 16'h0000;
         pulse_on <= 1'b0;
         decel_cnt <= 8'h00;
      end else begin
         state <= next_state;
         if (state == SPO_IDLE && start_req) begin
            dir_plus <= hwdata[SPO_CMD_DIR];
         end
         if (next_state == SPO_IDLE || tick_end) begin
            tick <= 16'h0000;
         end else begin
            tick <= tick + 16'h0001;
         end
         if (next_state == SPO_IDLE) begin
            pulse_on <= 1'b0;
         end else if (tick_end) begin
            pulse_on <= !pulse_on;
         end
         if (state == SPO_RUN) begin
            decel_cnt <= SPO_DECEL_PULSES;
         end else if (pulse_end) begin
            decel_cnt <= decel_cnt - 8'h01;
         end
      end
   end

   // sticky stop flag, cleared by writing its bit; the set wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stop_event <= 1'b0;
      end else if ((state == SPO_IDLE && start_req && stop_low) ||
            (state != SPO_IDLE && stop_low)) begin
         stop_event <= 1'b1;
      end else if (wr_pend && wr_addr == SPO_STAT_OFS && hwdata[SPO_ST_STOPEV]) begin
         stop_event <= 1'b0;
      end
   end

   // ==========================================================
   // pulse and phase output stage
   assign pulse_lvl = ctrl[SPO_CTL_PLOGIC] ? pulse_on : !pulse_on;
   assign mask_phase = ctrl[SPO_CTL_MLEVEL] ? 4'hC : 4'h0;
   assign next_phase = ctrl[SPO_CTL_PPORT] ? gpio_out :
      (ctrl[SPO_CTL_MASK] ? mask_phase : seq_phase);

   // output flip-flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         first_pulse_output <= 1'b1;
         second_pulse_output <= 1'b1;
         phase_output <= 4'h9;
         phase_oe <= 4'hF;
         origin_filtered_n <= 1'b1;
         plus_end_limit_filtered_n <= 1'b1;
         minus_end_limit_filtered_n <= 1'b1;
      end else if (reset_seen) begin
         if (ctrl[SPO_CTL_PMODE]) begin
            first_pulse_output <= pulse_lvl;
            second_pulse_output <= dir_plus;
         end else begin
            first_pulse_output <= dir_plus ? pulse_lvl : !ctrl[SPO_CTL_PLOGIC];
            second_pulse_output <= dir_plus ? !ctrl[SPO_CTL_PLOGIC] : pulse_lvl;
         end
         phase_output <= next_phase;
         phase_oe <= ctrl[SPO_CTL_PPORT] ? gpio_dir : 4'hF;
         origin_filtered_n <= org_n;
         plus_end_limit_filtered_n <= pel_n;
         minus_end_limit_filtered_n <= mel_n;
      end else begin
         phase_output <= seq_phase;
      end
   end
endmodule

/* File: hw/spo_pkg.sv */
// package of constants for the stepper pulse output stage
package spo_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] SPO_CTRL_OFS = 8'h00;
   localparam logic [7:0] SPO_CMD_OFS = 8'h04;
   localparam logic [7:0] SPO_STAT_OFS = 8'h08;
   // ==========================================================
   // control register field positions
   localparam int SPO_CTL_STOPDEC = 0;
   localparam int SPO_CTL_FILT = 1;
   localparam int SPO_CTL_PMODE = 2;
   localparam int SPO_CTL_PLOGIC = 3;
   localparam int SPO_CTL_PPORT = 4;
   localparam int SPO_CTL_MASK = 5;
   localparam int SPO_CTL_MLEVEL = 6;
   localparam logic [31:0] SPO_CTRL_RST = 32'h0000_0000;
   // ==========================================================
   // command register field positions
   localparam int SPO_CMD_START = 0;
   localparam int SPO_CMD_DIR = 1;
   localparam int SPO_CMD_HALT = 2;
   // ==========================================================
   // status register field positions
   localparam int SPO_ST_BUSY = 0;
   localparam int SPO_ST_STOPEV = 1;
   localparam int SPO_ST_STOPIN = 2;
   localparam int SPO_ST_ORIGIN = 4;
   localparam int SPO_ST_PHASE = 8;
   // ==========================================================
   // timing counts
   localparam int SPO_FILT_CYC = 4;
   localparam logic [15:0] SPO_HALF_PERIOD = 16'h0064;
   localparam logic [7:0] SPO_DECEL_PULSES = 8'h08;
   // ==========================================================
   // motion states
   typedef enum logic [2:0] {
      SPO_IDLE = 3'b001,
      SPO_RUN = 3'b010,
      SPO_DECEL = 3'b100
   } spo_state_e;
endpackage

/* File: hw/spo_seq_if.sv */
// interface between the sequencer and its user
`timescale 1ns/10ps
interface spo_seq_if;
   logic advance;
   logic dir_plus;
   logic half_step;
   logic bipolar;
   logic [3:0] phase;
   logic origin;
   modport seq(input advance, dir_plus, half_step, bipolar, output phase, origin);
   modport user(output advance, dir_plus, half_step, bipolar, input phase, origin);
endinterface

/* File: hw/spo_filter.sv */
// noise filter for one active-low mechanical input
`timescale 1ns/10ps
module spo_filter
   import spo_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic enable,
   input wire logic raw_n,
   output logic clean_n
);
   logic [2:0] cnt;
   logic stable;

   // ==========================================================
   // accept a new level only after it has stood four cycles
   assign stable = (cnt == 3'(SPO_FILT_CYC - 1));

   // counter of cycles the raw level differs from the accepted level
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 3'h0;
         clean_n <= 1'b1;
      end else if (!enable) begin
         cnt <= 3'h0;
         clean_n <= raw_n;
      end else if (raw_n == clean_n) begin
         cnt <= 3'h0;
      end else if (stable) begin
         cnt <= 3'h0;
         clean_n <= raw_n;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule

/* File: hw/spo_seq.sv */
// excitation sequencer for 2-2 and 1-2 phase drive
`timescale 1ns/10ps
module spo_seq
   import spo_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   spo_seq_if.seq sif
);
   logic [2:0] step;
   logic [2:0] next_step;
   logic [2:0] fwd;
   logic [2:0] bwd;

   // table lookup of phase levels, phase 1 in bit 0
   function automatic logic [3:0] spo_phase(input logic bip, input logic [2:0] s);
      logic [3:0] p;
      p = 4'h0;
      if (!bip) begin
         case (s)
            3'h0: p = 4'h9;
            3'h1: p = 4'h1;
            3'h2: p = 4'h3;
            3'h3: p = 4'h2;
            3'h4: p = 4'h6;
            3'h5: p = 4'h4;
            3'h6: p = 4'hC;
            default: p = 4'h8;
         endcase
      end else begin
         case (s)
            3'h0: p = 4'h1;
            3'h2: p = 4'h3;
            3'h4: p = 4'h2;
            3'h6: p = 4'h0;
            default: p = spo_phase_bip_half(s);
         endcase
      end
      return p;
   endfunction

   // bipolar odd steps shared with the half-step table
   function automatic logic [3:0] spo_phase_bip_half(input logic [2:0] s);
      logic [3:0] p;
      p = 4'h0;
      case (s)
         3'h1: p = 4'h1;
         3'h3: p = 4'h7;
         3'h5: p = 4'h2;
         default: p = 4'h4;
      endcase
      return p;
   endfunction

   // ==========================================================
   // full step moves two half steps; odd step goes to a two-phase step
   assign fwd = sif.half_step ? step + 3'h1 : ((step + 3'h2) & 3'h6);
   assign bwd = sif.half_step ? step - 3'h1 : (step[0] ? step - 3'h1 : step - 3'h2);
   assign next_step = sif.dir_plus ? fwd : bwd;
   assign sif.phase = spo_phase(sif.bipolar, step);
   assign sif.origin = (step == 3'h0);

   // step register, advanced at each pulse end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         step <= 3'h0;
      end else if (sif.advance) begin
         step <= next_step;
      end
   end
endmodule

/* File: test/spo_motor_model.sv */
// model of the motor driver stage, stop switch and port wiring
`timescale 1ns/10ps
module spo_motor_model (
   input wire logic clock,
   input wire logic pulse_on,
   input wire logic stop_req,
   input wire logic [3:0] phase,
   input wire logic [3:0] oe,
   output logic stop_n,
   output logic [3:0] gpio_in,
   output int pulses
);
   logic was_on = 1'b0;
   int cnt = 0;
   // ==========================================================
   // stop contact pulls the line to ground while closed
   assign stop_n = !stop_req;
   // port pins not driven by the block rest at the pull pattern
   assign gpio_in = (phase & oe) | (4'h5 & ~oe);
   assign pulses = cnt;
   // the driver takes one step per pulse, counted as it ends
   always @(posedge clock) begin
      was_on <= pulse_on;
      if (was_on && !pulse_on) begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* File: test/spo_top_checker.sv */
// assertion checker bound to the stepper pulse output stage
`timescale 1ns/10ps
module spo_top_checker
   import spo_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic external_stop_input_n,
   input wire logic origin_input_n,
   input wire logic origin_filtered_n,
   input wire logic plus_end_limit_input_n,
   input wire logic minus_end_limit_input_n,
   input wire logic plus_end_limit_filtered_n,
   input wire logic minus_end_limit_filtered_n,
   input wire logic first_pulse_output,
   input wire logic second_pulse_output,
   input wire logic [3:0] phase_output,
   input wire logic [3:0] phase_oe
);
   logic wp;
   logic [31:0] ctl;
   logic [2:0] age;
   logic [2:0] slo;
   // ==========================================================
   // control word shadow and settle counters
   wire take = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == SPO_CTRL_OFS);
   wire lands = wp & hready;
   wire [2:0] next_age = lands ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
   wire [2:0] next_slo = external_stop_input_n ? 3'h0 : (slo == 3'h7 ? slo : slo + 3'h1);
   wire settled = age > 3'h2;
   wire act = ctl[3];
   // a control write counts from the edge that ends its data phase
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wp <= 1'b0;
         ctl <= SPO_CTRL_RST;
         age <= 3'h0;
         slo <= 3'h0;
      end else begin
         wp <= take | (wp & !hready);
         ctl <= lands ? hwdata : ctl;
         age <= next_age;
         slo <= next_slo;
      end
   end
   // ==========================================================
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_reset_pattern:
   assert property ($rose(rstn) |-> phase_output inside {4'h9, 4'h1})
      else $error("phase pattern wrong after reset");
   a_stop_cuts:
   assert property (settled && ctl[1:0] == 2'b00 && $fell(external_stop_input_n)
      |-> ##4 (first_pulse_output != act) [*8]) else $error("pulse kept after stop");
   a_stop_no_pulse:
   assert property (slo == 3'h7 && settled && !ctl[0]
      |-> first_pulse_output != act && (ctl[2] || second_pulse_output != act))
      else $error("pulse while stop held");
   a_two_pulse_split:
   assert property (settled && !ctl[2]
      |-> !(first_pulse_output == act && second_pulse_output == act))
      else $error("both pulse outputs active");
   a_mask_low:
   assert property (settled && ctl[6:4] == 3'b010 |-> phase_output == 4'h0)
      else $error("low mask not applied");
   a_mask_high:
   assert property (settled && ctl[6:4] == 3'b110 |-> phase_output == 4'hC)
      else $error("high mask not applied");
   a_port_drive:
   assert property (settled && !ctl[4] |-> phase_oe == 4'hF)
      else $error("phase pins not driven");
   a_phase_on_off:
   assert property (settled && ctl[5:4] == 2'b00 && $changed(phase_output)
      |-> $past(first_pulse_output) == act || $past(second_pulse_output) == act
      || $past(first_pulse_output, 2) == act || $past(second_pulse_output, 2) == act)
      else $error("phase moved without a pulse ending");
   a_filter_width:
   assert property (settled && ctl[1] && $fell(origin_filtered_n)
      |-> $past(origin_input_n, 2) == 1'b0 && $past(origin_input_n, 3) == 1'b0
      && $past(origin_input_n, 4) == 1'b0 && $past(origin_input_n, 5) == 1'b0)
      else $error("short dip passed filter");
   a_raw_pass:
   assert property (settled && !ctl[1] && $fell(origin_input_n)
      |-> ##[1:4] !origin_filtered_n) else $error("unfiltered dip lost");
   a_limit_follow:
   assert property (settled && !ctl[1] |-> plus_end_limit_filtered_n ==
      $past(plus_end_limit_input_n, 2) && minus_end_limit_filtered_n ==
      $past(minus_end_limit_input_n, 2)) else $error("limit input not passed through");
   a_bus_okay:
   assert property (hreadyout && !hresp) else $error("slave not ready or not okay");
endmodule
bind spo_top spo_top_checker spo_top_checker_inst (.clock(clock), .rstn(rstn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .external_stop_input_n(external_stop_input_n), .origin_input_n(origin_input_n),
   .hreadyout(hreadyout), .hresp(hresp), .plus_end_limit_input_n(plus_end_limit_input_n),
   .minus_end_limit_input_n(minus_end_limit_input_n),
   .plus_end_limit_filtered_n(plus_end_limit_filtered_n),
   .minus_end_limit_filtered_n(minus_end_limit_filtered_n),
   .origin_filtered_n(origin_filtered_n), .first_pulse_output(first_pulse_output),
   .second_pulse_output(second_pulse_output), .phase_output(phase_output),
   .phase_oe(phase_oe));

/* File: test/tb_top.sv */
// self-checking bench for the stepper pulse output stage
`timescale 1ns/10ps
`define CHK(g, e) \
   begin \
      compares++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module tb_top
   import spo_pkg::*;
;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic stop_req = 1'b0;
   logic org_n = 1'b1;
   logic ub_sel = 1'b0;
   logic hs_sel = 1'b0;
   logic act_high = 1'b0;
   logic pmode1 = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, first_p, second_p, stop_n, org_f;
   logic [3:0] ph, oe, gpio_in;
   int pulses, p0;
   int num_errors = 0;
   int compares = 0;
   int idx = 0;
   bit bip = 1'b0;
   logic [3:0] uni [8] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8};
   logic [3:0] bif [4] = '{4'h1, 4'h3, 4'h2, 4'h0};
   wire pulse_on = (first_p == act_high) || (!pmode1 && second_p == act_high);
   // ==========================================================
   // block under test and its far side
   spo_top spo_top_inst (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .external_stop_input_n(stop_n),
      .origin_input_n(org_n), .plus_end_limit_input_n(org_n), .minus_end_limit_input_n(org_n),
      .unipolar_bipolar_select(ub_sel), .half_step_select(hs_sel), .gpio_in(gpio_in),
      .first_pulse_output(first_p), .second_pulse_output(second_p), .phase_output(ph),
      .phase_oe(oe), .origin_filtered_n(org_f), .plus_end_limit_filtered_n(),
      .minus_end_limit_filtered_n());
   spo_motor_model spo_motor_model_inst (.clock(clock), .pulse_on(pulse_on),
      .stop_req(stop_req), .phase(ph), .oe(oe), .stop_n(stop_n), .gpio_in(gpio_in),
      .pulses(pulses));
   initial begin
      forever #5 clock = ~clock;
   end
   // ==========================================================
   // one single ahb-lite transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask
   // wait for one step to end, then compare the phase pattern
   task automatic step(input int d);
      int p;
      p = pulses;
      for (int i = 0; i < 400 && pulses == p; i++) @(posedge clock);
      if (hs_sel || idx % 2)
         idx = (idx + d + 8) % 8;
      else
         idx = (idx + 2 * d + 8) % 8;
      repeat (3) @(posedge clock);
      `CHK(ph, bip ? bif[idx / 2] : uni[idx])
   endtask
   // poll status until motion has ended
   task automatic idle;
      for (int i = 0; i < 1000; i++) begin
         bus(0, SPO_STAT_OFS, 0);
         if (rd[SPO_ST_BUSY] === 1'b0) break;
      end
   endtask
   // drop the stop and origin lines for n cycles
   task automatic dip(input int n);
      stop_req <= 1'b1;
      org_n <= 1'b0;
      repeat (n) @(posedge clock);
      stop_req <= 1'b0;
      org_n <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic finish_test;
      $display("counts: errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      finish_test;
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK(ph, 4'h9)
      bus(0, SPO_STAT_OFS, 0);
      `CHK(rd[11:8], 4'h9)
      `CHK(rd[SPO_ST_ORIGIN], 1'b1)
      `CHK(oe, 4'hF)
      bus(0, SPO_CTRL_OFS, 0);
      `CHK(rd, SPO_CTRL_RST)
      bus(0, 8'h0C, 0);
      `CHK(rd, 32'h0)
      // full steps forward, cut short by the stop switch
      bus(1, SPO_CMD_OFS, 32'h3);
      repeat (3) step(1);
      stop_req <= 1'b1;
      repeat (6) @(posedge clock);
      `CHK({first_p, second_p}, 2'b11)
      bus(0, SPO_STAT_OFS, 0);
      `CHK(rd[2:0], 3'b110)
      stop_req <= 1'b0;
      bus(1, SPO_STAT_OFS, 32'h2);
      bus(0, SPO_STAT_OFS, 0);
      `CHK(rd[SPO_ST_STOPEV], 1'b0)
      // half steps backward, then full steps from an odd step
      hs_sel <= 1'b1;
      bus(1, SPO_CMD_OFS, 32'h1);
      repeat (3) step(-1);
      hs_sel <= 1'b0;
      repeat (2) step(-1);
      bus(1, SPO_CMD_OFS, 32'h4);
      idle;
      `CHK(rd[SPO_ST_BUSY], 1'b0)
      // pulse and direction form, active high
      pmode1 <= 1'b1;
      act_high <= 1'b1;
      bus(1, SPO_CTRL_OFS, 32'hC);
      repeat (3) @(posedge clock);
      `CHK(first_p, 1'b0)
      for (int d = 1; d >= -1; d -= 2) begin
         bus(1, SPO_CMD_OFS, d > 0 ? 32'h3 : 32'h1);
         step(d);
         `CHK(second_p, d > 0)
         bus(1, SPO_CMD_OFS, 32'h4);
         idle;
      end
      // decelerated stop runs out a fixed number of pulses
      pmode1 <= 1'b0;
      act_high <= 1'b0;
      bus(1, SPO_CTRL_OFS, 32'h1);
      bus(1, SPO_CMD_OFS, 32'h3);
      step(1);
      p0 = pulses;
      stop_req <= 1'b1;
      idle;
      repeat (4) @(posedge clock);
      `CHK(pulses - p0, int'(SPO_DECEL_PULSES))
      // a start while the switch is closed ends at once
      bus(1, SPO_CTRL_OFS, 32'h0);
      bus(1, SPO_STAT_OFS, 32'h2);
      p0 = pulses;
      bus(1, SPO_CMD_OFS, 32'h3);
      repeat (250) @(posedge clock);
      `CHK(pulses, p0)
      bus(0, SPO_STAT_OFS, 0);
      `CHK(rd[1:0], 2'b10)
      stop_req <= 1'b0;
      // filtered dips: three cycles ignored, four taken
      bus(1, SPO_CTRL_OFS, 32'h2);
      bus(1, SPO_CMD_OFS, 32'h3);
      step(1);
      dip(3);
      bus(0, SPO_STAT_OFS, 0);
      `CHK(rd[SPO_ST_BUSY], 1'b1)
      dip(4);
      idle;
      `CHK(rd[SPO_ST_BUSY], 1'b0)
      // unfiltered, a one cycle dip stops the motion
      bus(1, SPO_CTRL_OFS, 32'h0);
      bus(1, SPO_CMD_OFS, 32'h3);
      repeat (20) @(posedge clock);
      dip(1);
      idle;
      `CHK(rd[SPO_ST_BUSY], 1'b0)
      // masked phases and the port handed to general use
      bus(1, SPO_CTRL_OFS, 32'h20);
      repeat (3) @(posedge clock);
      `CHK(ph, 4'h0)
      bus(1, SPO_CTRL_OFS, 32'h60);
      repeat (3) @(posedge clock);
      `CHK(ph, 4'hC)
      bus(1, SPO_CTRL_OFS, 32'h0032_0010);
      repeat (3) @(posedge clock);
      `CHK(oe, 4'h3)
      bus(0, SPO_CMD_OFS, 0);
      `CHK(rd[3:0], 4'h6)
      // drive type is taken only while reset is held
      bus(1, SPO_CTRL_OFS, 32'h0);
      rstn <= 1'b0;
      ub_sel <= 1'b1;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      ub_sel <= 1'b0;
      bip = 1'b1;
      idx = 0;
      `CHK(ph, 4'h1)
      bus(1, SPO_CMD_OFS, 32'h3);
      repeat (2) step(1);
      finish_test;
   end
endmodule
